// ---- rlcm_top.sv ----
// receive line input stage with line clock loss monitor
`timescale 1ns/100ps
module rlcm_top
  import rlcm_pkg::*;
#(
  parameter int LOS_CYCLES = LOS_CYCLES_DEF,  // silence count, ref cycles
  parameter int BPV_WIDTH  = BPV_WIDTH_DEF    // violation counter width
)
(
  input  wire logic  ref_clk_i,               // 200 MHz reference clock
  input  wire logic  sys_rst_i,               // sync reset, active high
  input  wire logic  rx_line_clock_i,         // recovered line clock
  input  wire logic  positive_rail_rx_data_i, // positive rail data
  input  wire logic  negative_rail_rx_data_i, // negative rail data
  input  wire logic  single_rail_mode_i,      // 1 = single rail input
  input  wire logic  secondary_system_rx_serial_in_i, // highway input
  output logic       rx_pos_data_o,           // received positive bit
  output logic       rx_neg_data_o,           // received negative bit
  output logic       rx_bit_valid_o,          // one pulse per line bit
  output logic [BPV_WIDTH-1:0] bpv_count_o,   // bipolar violation count
  output logic       line_clock_lost_flag_o,  // line clock lost
  output logic       secondary_sys_rx_data_o  // highway data, synced
);

  localparam int CNT_W = $clog2(LOS_CYCLES + 1);  // watchdog width
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOS_CYCLES - 1);

  // ****************************************************************
  // line domain capture
  // ****************************************************************
  rlcm_xing_if xing ();                       // crossing bundle

  rlcm_line_capture u_line (
    .rx_line_clock_i         (rx_line_clock_i),
    .sys_rst_i               (sys_rst_i),
    .positive_rail_rx_data_i (positive_rail_rx_data_i),
    .negative_rail_rx_data_i (negative_rail_rx_data_i),
    .xing                    (xing.line)
  );

  // ****************************************************************
  // synchronisers into the reference domain
  // ****************************************************************
  logic [2:0] lclk_q;                         // line clock level samples
  logic [2:0] tog_q;                          // bit toggle samples
  logic [1:0] mode_q;                         // single rail mode pin
  logic [1:0] sec_q;                          // highway data pin
  logic       clk_edge;                       // any line clock edge
  logic       new_bit;                        // a line bit has arrived

  // stage 0 of each chain feeds stage 1 only
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      lclk_q <= 3'h0;
      tog_q  <= 3'h0;
      mode_q <= 2'h0;
      sec_q  <= 2'h0;
    end
    else
    begin
      lclk_q <= {lclk_q[1:0], rx_line_clock_i};
      tog_q  <= {tog_q[1:0], xing.bit_toggle};
      mode_q <= {mode_q[0], single_rail_mode_i};
      sec_q  <= {sec_q[0], secondary_system_rx_serial_in_i};
    end
  end

  // both rising and falling edges count as activity
  assign clk_edge = lclk_q[2] ^ lclk_q[1];
  assign new_bit  = tog_q[2] ^ tog_q[1];

  // ****************************************************************
  // loss of line clock watchdog
  // ****************************************************************
  logic [CNT_W-1:0] idle_cnt_q;               // cycles since last edge

  // R9 restart on edge
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || clk_edge)
      idle_cnt_q <= '0;
    else if (idle_cnt_q != CNT_LAST)
      idle_cnt_q <= idle_cnt_q + CNT_W'(1);   // saturates at the limit
  end

  // R1 raise after silence
  // R2 clear on any edge
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      line_clock_lost_flag_o <= FLAG_RST_VAL;
    else if (clk_edge)
      line_clock_lost_flag_o <= 1'h0;         // clock is back
    else if (idle_cnt_q == CNT_LAST)
      line_clock_lost_flag_o <= 1'h1;         // full interval silent
  end

  // ****************************************************************
  // received bits and violation counting
  // ****************************************************************
  // data words are held a whole line period, so they are read
  // directly once the toggle has passed its synchroniser
  // R5 single rail data
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_pos_data_o  <= 1'h0;
      rx_neg_data_o  <= 1'h0;
      rx_bit_valid_o <= 1'h0;
    end
    else
    begin
      rx_bit_valid_o <= new_bit;
      if (new_bit)
      begin
        rx_pos_data_o <= xing.pos_bit;
        // single rail: negative rail marks violations, not data
        rx_neg_data_o <= xing.neg_bit & ~mode_q[1];
      end
    end
  end

  // R7 violation counter
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      bpv_count_o <= '0;
    else if (new_bit && mode_q[1] && xing.neg_bit)
      bpv_count_o <= bpv_count_o + BPV_WIDTH'(1);  // wraps when full
  end

  // highway input only needs to reach this clock cleanly
  assign secondary_sys_rx_data_o = sec_q[1];

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_lost_raise;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (idle_cnt_q == CNT_LAST && !clk_edge) |=> line_clock_lost_flag_o;
  endproperty
  a_lost_raise: assert property (p_lost_raise) // R1
    else $error("flag not raised after silent interval");

  property p_lost_early;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(line_clock_lost_flag_o) |-> $past(idle_cnt_q) == CNT_LAST;
  endproperty
  a_lost_early: assert property (p_lost_early) // R1
    else $error("flag raised before interval elapsed");

  property p_lost_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (line_clock_lost_flag_o && clk_edge) |=> !line_clock_lost_flag_o;
  endproperty
  a_lost_clear: assert property (p_lost_clear) // R2
    else $error("flag not cleared on line clock edge");

  property p_restart;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_edge |=> idle_cnt_q == '0
                 ##1 (idle_cnt_q == CNT_W'(1) || $past(clk_edge));
  endproperty
  a_restart: assert property (p_restart) // R9
    else $error("watchdog not restarted by edge");

  property p_single_neg;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (new_bit && mode_q[1]) |=> !rx_neg_data_o && rx_bit_valid_o;
  endproperty
  a_single_neg: assert property (p_single_neg) // R5
    else $error("negative data passed in single rail mode");

  property p_bpv_count;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (new_bit && mode_q[1] && xing.neg_bit)
      |=> bpv_count_o == $past(bpv_count_o) + BPV_WIDTH'(1);
  endproperty
  a_bpv_count: assert property (p_bpv_count) // R7
    else $error("violation not counted");

  // line bits are far apart, so valid never stands two cycles
  property p_valid_pulse;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rx_bit_valid_o |=> !rx_bit_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) // R3
    else $error("bit valid held longer than one cycle");

  property p_dual_data;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (new_bit && !mode_q[1])
      |=> rx_pos_data_o == $past(xing.pos_bit)
          && rx_neg_data_o == $past(xing.neg_bit);
  endproperty
  a_dual_data: assert property (p_dual_data) // R6
    else $error("dual rail bits not passed through");

  property p_single_pos;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (new_bit && mode_q[1]) |=> rx_pos_data_o == $past(xing.pos_bit);
  endproperty
  a_single_pos: assert property (p_single_pos) // R5
    else $error("single rail data not taken from positive rail");

  property p_bpv_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !(new_bit && mode_q[1] && xing.neg_bit)
      |=> bpv_count_o == $past(bpv_count_o);
  endproperty
  a_bpv_hold: assert property (p_bpv_hold) // R7
    else $error("violation count moved without a violation");

  property p_lost_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (line_clock_lost_flag_o && !clk_edge) |=> line_clock_lost_flag_o;
  endproperty
  a_lost_hold: assert property (p_lost_hold) // R2
    else $error("flag dropped without a line clock edge");

  property p_lost_low;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (!line_clock_lost_flag_o && idle_cnt_q != CNT_LAST)
      |=> !line_clock_lost_flag_o;
  endproperty
  a_lost_low: assert property (p_lost_low) // R1
    else $error("flag raised while interval still running");

endmodule : rlcm_top

// ---- rlcm_pkg.sv ----
// constants shared by the receive line input and clock monitor block
// Contract
// R1 - flag high after 250 us without clock edge
// R2 - first line clock edge clears the flag
// R3 - line side supplies 1.544 or 2.048 MHz
// R4 - positive rail captured on rising line edge
// R5 - single rail takes data from positive rail
// R6 - dual rail captures negative rail on rising edge
// R7 - single rail: negative rail high counts violation
// R8 - system side supplies serial data at highway rate
// R9 - reference clock times interval, edges restart it
package rlcm_pkg;

  // ****************************************************************
  // timing of the loss-of-clock watchdog
  // ****************************************************************
  localparam int REF_PERIOD_PS  = 5000;      // reference clock period
  localparam int LOS_TIME_NS    = 250000;    // silence before the flag
  // longest time, so the cycle count rounds down
  localparam int LOS_CYCLES_DEF = (LOS_TIME_NS * 1000) / REF_PERIOD_PS;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int BPV_WIDTH_DEF  = 16;        // violation counter width
  localparam int SYNC_RST_LEN   = 2;         // line domain reset stages
  localparam logic FLAG_RST_VAL = 1'h0;      // flag value after reset

endpackage : rlcm_pkg

// ---- rlcm_xing_if.sv ----
// bundle carrying captured rail bits from the line clock domain
`timescale 1ns/100ps
interface rlcm_xing_if;
  logic bit_toggle;                          // flips once per line bit
  logic pos_bit;                             // captured positive rail
  logic neg_bit;                             // captured negative rail

  // line side produces, core side consumes
  modport line (output bit_toggle, output pos_bit, output neg_bit);
  modport core (input bit_toggle, input pos_bit, input neg_bit);
endinterface : rlcm_xing_if

// ---- rlcm_line_capture.sv ----
// rail capture logic running on the receive line clock
`timescale 1ns/100ps
module rlcm_line_capture
  import rlcm_pkg::*;
(
  input  wire logic  rx_line_clock_i,         // recovered line clock
  input  wire logic  sys_rst_i,               // reset, reference domain
  input  wire logic  positive_rail_rx_data_i, // positive rail data
  input  wire logic  negative_rail_rx_data_i, // negative rail data
  rlcm_xing_if.line  xing                     // toward the core
);

  // ****************************************************************
  // reset carried into the line domain
  // ****************************************************************
  logic [SYNC_RST_LEN-1:0] rst_sync_q;        // reset shift chain
  logic                    line_rst;          // reset in line domain

  // the line clock may stand still, so reset only lands once it runs
  always_ff @(posedge rx_line_clock_i)
  begin
    rst_sync_q <= {rst_sync_q[SYNC_RST_LEN-2:0], sys_rst_i};
  end

  assign line_rst = rst_sync_q[SYNC_RST_LEN-1];

  // ****************************************************************
  // rail sampling
  // ****************************************************************
  // R4 positive rail capture
  // R6 negative rail capture
  always_ff @(posedge rx_line_clock_i)
  begin
    if (line_rst)
    begin
      xing.pos_bit    <= 1'h0;
      xing.neg_bit    <= 1'h0;
      xing.bit_toggle <= 1'h0;
    end
    else
    begin
      // toggle moves with the data, so data is stable when it is seen
      xing.pos_bit    <= positive_rail_rx_data_i;
      xing.neg_bit    <= negative_rail_rx_data_i;
      xing.bit_toggle <= ~xing.bit_toggle;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // the chain is unknown until the line clock has run inside reset,
  // so the pin reset also masks these checks
  property p_pos_capture;
    @(posedge rx_line_clock_i) disable iff (sys_rst_i || line_rst)
    1'b1 |=> (xing.pos_bit == $past(positive_rail_rx_data_i)
              && xing.bit_toggle != $past(xing.bit_toggle));
  endproperty
  a_pos_capture: assert property (p_pos_capture) // R4
    else $error("positive rail not captured on rising edge");

  property p_neg_capture;
    @(posedge rx_line_clock_i) disable iff (sys_rst_i || line_rst)
    1'b1 |=> xing.neg_bit == $past(negative_rail_rx_data_i);
  endproperty
  a_neg_capture: assert property (p_neg_capture) // R6
    else $error("negative rail not captured on rising edge");

endmodule : rlcm_line_capture

// ---- rlcm_liu_model.sv ----
// line interface unit model: recovered line clock and both rails
`timescale 1ns/100ps
module rlcm_liu_model #(
  parameter real HALF_NS = 80.0             // half line clock period
)
(
  input  wire logic run_i,                  // 1 = line clock toggles
  input  wire logic pos_i,                  // next positive rail bit
  input  wire logic neg_i,                  // next negative rail bit
  output logic      line_clk_o,             // recovered line clock
  output logic      pos_o,                  // positive rail to framer
  output logic      neg_o                   // negative rail to framer
);
  // ****************************************************************
  // clock source and rail drivers
  // ****************************************************************
  initial
  begin
    line_clk_o = 1'h0;
    pos_o      = 1'h0;
    neg_o      = 1'h0;
  end
  // line clock source
  // holds its level while stopped, so a loss can end on either edge
  always
  begin
    #(HALF_NS);
    if (run_i)
      line_clk_o = ~line_clk_o;
  end
  // rails move on the falling edge: half a period of setup
  always @(negedge line_clk_o)
  begin
    pos_o <= pos_i;
    neg_o <= neg_i;
  end
endmodule : rlcm_liu_model

// ---- rlcm_top_tb.sv ----
// self-checking bench for the line input and clock loss monitor
`timescale 1ns/100ps
module rlcm_top_tb;
  typedef struct packed {logic md, p, n, ep, en, inc;} rlcm_row_t;
  localparam int LOS = 200;                 // short silence count
  logic ref_clk_i = 1'h0;                   // 200 MHz reference
  logic sys_rst_i = 1'h1;                   // sync reset
  logic run = 1'h1, pi = 1'h0, ni = 1'h0;   // model controls
  logic md = 1'h0, hw = 1'h0;               // mode, highway input
  logic line_clk, pos, neg, rxp, rxn, vld, lost, hwo; // wires
  logic [15:0] bpv, b0;                     // count, snapshot
  int n_errors = 0, n_compared = 0;         // verdict counters
  rlcm_row_t rows [6] = '{6'h20, 6'h0A, 6'h1E, 6'h3D, 6'h29, 6'h34};
  always #2.5 ref_clk_i = ~ref_clk_i;
  rlcm_liu_model u_rlcm_liu_model (.run_i(run), .pos_i(pi), .neg_i(ni),
    .line_clk_o(line_clk), .pos_o(pos), .neg_o(neg));
  rlcm_top #(.LOS_CYCLES(LOS), .BPV_WIDTH(16)) u_rlcm_top (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .rx_line_clock_i(line_clk), .positive_rail_rx_data_i(pos),
    .negative_rail_rx_data_i(neg), .single_rail_mode_i(md),
    .secondary_system_rx_serial_in_i(hw), .rx_pos_data_o(rxp),
    .rx_neg_data_o(rxn), .rx_bit_valid_o(vld), .bpv_count_o(bpv),
    .line_clock_lost_flag_o(lost), .secondary_sys_rx_data_o(hwo));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic report_and_stop;
    $display("counts: %0d compared, %0d errors", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // a wait that runs out ends the run
  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      n_errors++;
      report_and_stop;
    end
  endtask : bound
  task automatic wait_valid;
    int k;
    k = 0;
    @(posedge ref_clk_i);
    while (vld !== 1'h1 && k < 200)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    bound(k, 200);
  endtask : wait_valid
  // stop the line clock at level lvl, then restart it
  task automatic loss_test(input logic lvl);
    int k;
    // wait for the edge itself, so the silence starts right here
    k = 0;
    while (line_clk === lvl && k < 100)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    bound(k, 100);
    k = 0;
    while (line_clk !== lvl && k < 100)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    bound(k, 100);
    run <= 1'h0;
    repeat (LOS - 5) @(posedge ref_clk_i);
    check(lost, 1'h0);
    k = 0;
    while (lost !== 1'h1 && k < 20)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    check(lost, 1'h1);
    repeat (20) @(posedge ref_clk_i);
    check(lost, 1'h1);
    run <= 1'h1;
    k = 0;
    while (line_clk === lvl && k < 100)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    bound(k, 100);
    repeat (6) @(posedge ref_clk_i);
    check(lost, 1'h0);
    $display("test loss with clock stopped at %0d done", lvl);
  endtask : loss_test
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    // line domain needs several line edges inside reset
    repeat (5) @(posedge line_clk);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    @(posedge ref_clk_i);
    check(lost, 1'h0);
    check(vld, 1'h0);
    check(bpv, 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      @(posedge ref_clk_i);
      md <= rows[i].md;
      pi <= rows[i].p;
      ni <= rows[i].n;
      wait_valid;
      wait_valid;
      b0 = bpv;
      wait_valid;
      check(rxp, rows[i].ep);
      check(rxn, rows[i].en);
      check(bpv, 16'(b0 + rows[i].inc));
      $display("test row %0d done", i);
    end
    // violations on back-to-back bits each count once
    @(posedge ref_clk_i);
    ni <= 1'h1;
    repeat (2) wait_valid;
    b0 = bpv;
    repeat (3) wait_valid;
    check(bpv, 16'(b0 + 16'h0003));
    $display("test back to back violations done");
    for (int j = 0; j < 3; j++)
    begin
      @(posedge ref_clk_i);
      hw <= ~hw;
      repeat (4) @(posedge ref_clk_i);
      check(hwo, hw);
    end
    $display("test highway input done");
    loss_test(1'h1);
    loss_test(1'h0);
    report_and_stop;
  end
endmodule : rlcm_top_tb
